//--- cmc_pkg.sv
// package: register map, field positions, reset values and timing counts of the mode control block
package cmc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CMC_OFF_CTL0 = 8'h00;
    localparam logic [7:0] CMC_OFF_CTL1 = 8'h01;
    localparam logic [7:0] CMC_OFF_BTR0 = 8'h02;
    localparam logic [7:0] CMC_OFF_BTR1 = 8'h03;
    localparam logic [7:0] CMC_OFF_RFLG = 8'h04;
    localparam logic [7:0] CMC_OFF_IDAC = 8'h0b;
    localparam logic [7:0] CMC_OFF_STAT = 8'h0c;
    localparam logic [7:0] CMC_OFF_IDAR = 8'h10;
    localparam logic [7:0] CMC_OFF_IDMR = 8'h18;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CMC_C0_INIT_REQ = 0;
    localparam int CMC_C0_SLEEP_REQ = 1;
    localparam int CMC_C0_WAKE_EN = 2;
    localparam int CMC_C0_TIMER_EN = 3;
    localparam int CMC_C0_STOP_WAIT = 5;
    localparam int CMC_C1_ENABLE = 7;
    localparam int CMC_C1_CLK_SRC = 6;
    localparam int CMC_C1_LOOPBACK = 5;
    localparam int CMC_C1_LISTEN = 4;
    localparam int CMC_C1_WAKE_FILT = 2;
    localparam int CMC_C1_SLEEP_ACK = 1;
    localparam int CMC_C1_INIT_ACK = 0;
    localparam int CMC_RF_WAKE = 7;
    localparam int CMC_RF_RX_STATE = 4;
    localparam int CMC_RF_TX_STATE = 2;
    localparam int CMC_RF_RX_FRAME = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic CMC_RST_INIT_REQ = 1'b1;
    localparam logic CMC_RST_LISTEN = 1'b1;
    localparam logic [7:0] CMC_RST_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CMC_CLK_PERIOD_NS = 4;
    localparam int CMC_TWUP_NS = 2000;
    localparam int CMC_TWUP_CYCLES = (CMC_TWUP_NS + CMC_CLK_PERIOD_NS - 1) / CMC_CLK_PERIOD_NS;
    localparam int CMC_IDLE_BITS = 11;
    localparam int CMC_BUSOFF_SEQS = 128;

    typedef enum logic [1:0] {CMC_RUN, CMC_INIT, CMC_RESYNC} cmc_mode_type;

endpackage

//--- cmc_wake_filter.sv
// wake-up detector: raw dominant level or dominant pulse of a least length
`timescale 1ns/10ps
`default_nettype none
module cmc_wake_filter
    import cmc_pkg::*;
#(
    parameter int CYCLES = CMC_TWUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic rx_bit,
    input wire logic filter_sel,
    output logic wake
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] run_len;
    wire dominant = enable & ~rx_bit;
    wire long_enough = dominant & (run_len == LAST);
    // unfiltered wakes on the first dominant sample; filtered needs the whole pulse
    wire hit = filter_sel ? long_enough : dominant;

    // ------------------------------------------------------------------
    // dominant run length; any recessive sample restarts the filter
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn || !dominant) begin
            run_len <= '0;
        end else if (run_len != LAST) begin
            run_len <= run_len + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wake <= 1'b0;
        end else begin
            wake <= hit;
        end
    end
endmodule
`default_nettype wire

//--- cmc_resync.sv
// bus integration counter: 11 recessive bits, or 128 such runs when bus-off
`timescale 1ns/10ps
`default_nettype none
module cmc_resync
    import cmc_pkg::*;
#(
    parameter int IDLE_BITS = CMC_IDLE_BITS,
    parameter int BUSOFF_SEQS = CMC_BUSOFF_SEQS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic active,
    input wire logic bit_tick,
    input wire logic rx_bit,
    input wire logic bus_off,
    output logic done
);
    localparam logic [3:0] BITS_LAST = 4'(IDLE_BITS - 1);
    localparam logic [7:0] SEQ_LAST = 8'(BUSOFF_SEQS - 1);

    logic [3:0] bit_cnt;
    logic [7:0] seq_cnt;
    wire run_end = bit_tick & rx_bit & (bit_cnt == BITS_LAST);
    wire finished = run_end & (!bus_off || seq_cnt == SEQ_LAST);

    // ------------------------------------------------------------------
    // a dominant bit restarts only the current run, not the run count
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn || !active) begin
            bit_cnt <= '0;
            seq_cnt <= '0;
        end else if (bit_tick) begin
            if (!rx_bit || run_end) begin
                bit_cnt <= '0;
            end else begin
                bit_cnt <= bit_cnt + 1'b1;
            end
            if (run_end) begin
                seq_cnt <= seq_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            done <= 1'b0;
        end else begin
            done <= active & finished;
        end
    end
endmodule
`default_nettype wire

//--- cmc_mode_ctrl.sv
// mode control: control registers, sleep and init handshakes, transmit pin safety
//
// Functional notes
// - stop, or wait with stop_in_wait, forces recessive
// - init request forces transmit pin recessive at once
// - sleep request clear ignored until sleep acknowledged
// - init request clear ignored until init acknowledged
// - init entry resets control 0 except three bits
// - init keeps tx/rx state fields, clears flags
// - control 1 always readable, writable only in init
// - enable bit write-once normal, repeatable special
// - clock source bit selects oscillator or bus clock
// - loopback feeds transmitter to receiver, pin recessive
// - loopback frame counts as received, ack ignored
// - listen-only receives, sends no ack or errors
// - listen-only freezes error counters, blocks transmission
// - wake filter select: any dominant or long pulse
// - sleep ack set on sleep, cleared on wake
// - init ack flag reports init mode entered
// - timing and acceptance registers writable only in init
// - sleep entered only while bus idle
// - init request aborts traffic and drops synchronization
// - resync after 11 recessive bits, 128 runs bus-off
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cmc_mode_ctrl
    import cmc_pkg::*;
#(
    parameter int TWUP_CYCLES = CMC_TWUP_CYCLES,
    parameter int IDLE_BITS = CMC_IDLE_BITS,
    parameter int BUSOFF_SEQS = CMC_BUSOFF_SEQS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic special_mode,
    input wire logic cpu_stop,
    input wire logic cpu_wait,
    input wire logic bus_rx_pin,
    input wire logic pe_tx_bit,
    input wire logic pe_rx_busy,
    input wire logic pe_tx_pending,
    input wire logic pe_bus_off,
    input wire logic pe_bit_tick,
    input wire logic pe_rx_frame_event,
    input wire logic [1:0] tx_state_field_in,
    input wire logic [1:0] rx_state_field_in,
    output logic bus_tx_pin,
    output logic pe_rx_bit,
    output logic pe_abort,
    output logic pe_synced,
    output logic pe_loopback,
    output logic pe_ack_enable,
    output logic pe_err_frame_enable,
    output logic pe_counter_freeze,
    output logic pe_tx_enable,
    output logic module_enable_bit,
    output logic clock_source_select,
    output logic timer_enable,
    output logic [7:0] bit_timing_reg_0,
    output logic [7:0] bit_timing_reg_1,
    output logic [7:0] acceptance_control_reg
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    cmc_mode_type mode;
    cmc_mode_type next_mode;
    logic init_request;
    logic sleep_request;
    logic wake_enable;
    logic stop_in_wait;
    logic init_ack;
    logic sleep_ack;
    logic enable_locked;
    logic loopback_select;
    logic listen_only;
    logic wake_filter_select;
    logic wake_flag;
    logic rx_frame_flag;
    logic [1:0] tx_state_field;
    logic [1:0] rx_state_field;
    logic [7:0] acceptance_code_regs [0:7];
    logic [7:0] acceptance_mask_regs [0:7];
    logic wake_hit;
    logic resync_done;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire init_active = init_request & init_ack;
    wire wr_ctl0 = reg_wr & (reg_addr == CMC_OFF_CTL0);
    wire wr_ctl1 = reg_wr & (reg_addr == CMC_OFF_CTL1) & init_active;
    wire wr_btr0 = reg_wr & (reg_addr == CMC_OFF_BTR0) & init_active;
    wire wr_btr1 = reg_wr & (reg_addr == CMC_OFF_BTR1) & init_active;
    wire wr_idac = reg_wr & (reg_addr == CMC_OFF_IDAC) & init_active;
    wire wr_rflg = reg_wr & (reg_addr == CMC_OFF_RFLG) & ~init_active;
    wire wr_idar = reg_wr & (reg_addr[7:3] == CMC_OFF_IDAR[7:3]) & init_active;
    wire wr_idmr = reg_wr & (reg_addr[7:3] == CMC_OFF_IDMR[7:3]) & init_active;
    wire [2:0] acc_idx = reg_addr[2:0];

    // ------------------------------------------------------------------
    // handshake requests
    // ------------------------------------------------------------------
    // a wake that meets a sleep request write in the same cycle wins and clears the request
    wire bus_idle = ~pe_rx_busy & ~pe_tx_pending;
    wire woke = wake_hit & sleep_ack & wake_enable;
    wire next_init_request = wr_ctl0
        ? (reg_wdata[CMC_C0_INIT_REQ] | (init_request & ~init_ack))
        : init_request;
    wire sleep_wr_val = reg_wdata[CMC_C0_SLEEP_REQ] & ~wake_flag;
    wire sleep_wr = sleep_wr_val | (sleep_request & ~sleep_ack);
    wire next_sleep_request = woke ? 1'b0 : (wr_ctl0 ? sleep_wr : sleep_request);
    wire entering_init = init_request & (mode != CMC_INIT);
    wire next_sleep_ack = sleep_request & ~woke & ~init_request
        & (sleep_ack | (bus_idle & mode == CMC_RUN));
    wire enable_wr_ok = wr_ctl1 & (special_mode | ~enable_locked);

    // ------------------------------------------------------------------
    // mode sequencer: run, init, bus integration after init
    // ------------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        case (mode)
            CMC_RUN: begin
                if (init_request) begin
                    next_mode = CMC_INIT;
                end
            end
            CMC_INIT: begin
                if (!init_request) begin
                    next_mode = CMC_RESYNC;
                end
            end
            CMC_RESYNC: begin
                if (init_request) begin
                    next_mode = CMC_INIT;
                end else if (resync_done) begin
                    next_mode = CMC_RUN;
                end
            end
            default: begin
                next_mode = CMC_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mode <= CMC_INIT;
            init_ack <= CMC_RST_INIT_REQ;
        end else begin
            mode <= next_mode;
            init_ack <= (next_mode == CMC_INIT);
        end
    end

    // ------------------------------------------------------------------
    // control 0: requests and wake enable survive init entry, stop_in_wait and timer_enable are held cleared
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            init_request <= CMC_RST_INIT_REQ;
            sleep_request <= 1'b0;
            wake_enable <= 1'b0;
            stop_in_wait <= 1'b0;
            timer_enable <= 1'b0;
        end else begin
            init_request <= next_init_request;
            sleep_request <= next_sleep_request;
            if (wr_ctl0) begin
                wake_enable <= reg_wdata[CMC_C0_WAKE_EN];
            end
            if (entering_init || init_active) begin
                stop_in_wait <= 1'b0;
                timer_enable <= 1'b0;
            end else if (wr_ctl0) begin
                stop_in_wait <= reg_wdata[CMC_C0_STOP_WAIT];
                timer_enable <= reg_wdata[CMC_C0_TIMER_EN];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sleep_ack <= 1'b0;
        end else begin
            sleep_ack <= next_sleep_ack;
        end
    end

    // ------------------------------------------------------------------
    // control 1 configuration, changeable only inside init
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            module_enable_bit <= 1'b0;
            enable_locked <= 1'b0;
            clock_source_select <= 1'b0;
            loopback_select <= 1'b0;
            listen_only <= CMC_RST_LISTEN;
            wake_filter_select <= 1'b0;
        end else begin
            if (enable_wr_ok) begin
                module_enable_bit <= reg_wdata[CMC_C1_ENABLE];
                enable_locked <= 1'b1;
            end
            if (wr_ctl1) begin
                clock_source_select <= reg_wdata[CMC_C1_CLK_SRC];
                loopback_select <= reg_wdata[CMC_C1_LOOPBACK];
                listen_only <= reg_wdata[CMC_C1_LISTEN];
                wake_filter_select <= reg_wdata[CMC_C1_WAKE_FILT];
            end
        end
    end

    // ------------------------------------------------------------------
    // timing and acceptance registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bit_timing_reg_0 <= CMC_RST_BYTE;
            bit_timing_reg_1 <= CMC_RST_BYTE;
            acceptance_control_reg <= CMC_RST_BYTE;
        end else begin
            if (wr_btr0) begin
                bit_timing_reg_0 <= reg_wdata;
            end
            if (wr_btr1) begin
                bit_timing_reg_1 <= reg_wdata;
            end
            if (wr_idac) begin
                acceptance_control_reg <= reg_wdata;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_acc
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    acceptance_code_regs[gi] <= CMC_RST_BYTE;
                    acceptance_mask_regs[gi] <= CMC_RST_BYTE;
                end else begin
                    if (wr_idar && acc_idx == 3'(gi)) begin
                        acceptance_code_regs[gi] <= reg_wdata;
                    end
                    if (wr_idmr && acc_idx == 3'(gi)) begin
                        acceptance_mask_regs[gi] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // receiver flags: write one clears, init clears flags but not states
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wake_flag <= 1'b0;
            rx_frame_flag <= 1'b0;
            tx_state_field <= 2'h0;
            rx_state_field <= 2'h0;
        end else begin
            tx_state_field <= tx_state_field_in;
            rx_state_field <= rx_state_field_in;
            if (init_active) begin
                wake_flag <= 1'b0;
                rx_frame_flag <= 1'b0;
            end else begin
                wake_flag <= woke | (wake_flag & ~(wr_rflg & reg_wdata[CMC_RF_WAKE]));
                rx_frame_flag <= pe_rx_frame_event
                    | (rx_frame_flag & ~(wr_rflg & reg_wdata[CMC_RF_RX_FRAME]));
            end
        end
    end

    // ------------------------------------------------------------------
    // pin and protocol engine controls
    // ------------------------------------------------------------------
    // every route to a dominant bit passes this gate, so a late mode
    // change can never leave the pin driven dominant
    wire force_recessive = cpu_stop | (cpu_wait & stop_in_wait)
        | init_request
        | loopback_select
        | listen_only
        | (mode != CMC_RUN) | sleep_ack | ~module_enable_bit;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bus_tx_pin <= 1'b1;
            pe_rx_bit <= 1'b1;
            pe_abort <= CMC_RST_INIT_REQ;
            pe_synced <= 1'b0;
            pe_loopback <= 1'b0;
            pe_ack_enable <= 1'b0;
            pe_err_frame_enable <= 1'b0;
            pe_counter_freeze <= CMC_RST_LISTEN;
            pe_tx_enable <= 1'b0;
        end else begin
            bus_tx_pin <= force_recessive | pe_tx_bit;
            pe_rx_bit <= loopback_select ? pe_tx_bit : bus_rx_pin;
            pe_abort <= init_request;
            pe_synced <= (next_mode == CMC_RUN);
            pe_loopback <= loopback_select;
            pe_ack_enable <= ~listen_only & ~loopback_select;
            pe_err_frame_enable <= ~listen_only;
            pe_counter_freeze <= listen_only;
            pe_tx_enable <= ~listen_only & module_enable_bit;
        end
    end

    // ------------------------------------------------------------------
    // read path: one cycle latency, unmapped addresses read zero
    // ------------------------------------------------------------------
    wire [7:0] ctl0_view = {2'b00, stop_in_wait, 1'b0, timer_enable,
        wake_enable, sleep_request, init_request};
    wire [7:0] ctl1_view = {module_enable_bit, clock_source_select, loopback_select,
        listen_only, 1'b0, wake_filter_select, sleep_ack, init_ack};
    wire [7:0] rflg_view = {wake_flag, 1'b0, rx_state_field, tx_state_field,
        1'b0, rx_frame_flag};
    wire [7:0] stat_view = {6'h00, pe_bus_off, pe_synced};
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr[7:3] == CMC_OFF_IDAR[7:3]) begin
            next_rdata = acceptance_code_regs[acc_idx];
        end else if (reg_addr[7:3] == CMC_OFF_IDMR[7:3]) begin
            next_rdata = acceptance_mask_regs[acc_idx];
        end else begin
            case (reg_addr)
                CMC_OFF_CTL0: next_rdata = ctl0_view;
                CMC_OFF_CTL1: next_rdata = ctl1_view;
                CMC_OFF_BTR0: next_rdata = bit_timing_reg_0;
                CMC_OFF_BTR1: next_rdata = bit_timing_reg_1;
                CMC_OFF_RFLG: next_rdata = rflg_view;
                CMC_OFF_IDAC: next_rdata = acceptance_control_reg;
                CMC_OFF_STAT: next_rdata = stat_view;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    cmc_wake_filter #(.CYCLES(TWUP_CYCLES)) u_wake (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .enable(sleep_ack & wake_enable),
        .rx_bit(bus_rx_pin),
        .filter_sel(wake_filter_select),
        .wake(wake_hit)
    );

    cmc_resync #(.IDLE_BITS(IDLE_BITS), .BUSOFF_SEQS(BUSOFF_SEQS)) u_resync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .active(mode == CMC_RESYNC),
        .bit_tick(pe_bit_tick),
        .rx_bit(pe_rx_bit),
        .bus_off(pe_bus_off),
        .done(resync_done)
    );
endmodule
`default_nettype wire

//--- cmc_mode_ctrl_asserts.sv
// checker: port relations of the mode control block
`timescale 1ns/10ps
`default_nettype none
module cmc_mode_ctrl_asserts (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cpu_stop,
    input wire logic pe_tx_bit,
    input wire logic bus_tx_pin,
    input wire logic pe_abort,
    input wire logic pe_synced,
    input wire logic pe_loopback,
    input wire logic pe_ack_enable,
    input wire logic pe_counter_freeze,
    input wire logic pe_tx_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // transmit pin safety, handshake, listen-only and read data relations
    // ------------------------------------------------------------------
    property p_stop; cpu_stop |=> bus_tx_pin; endproperty
    a_stop: assert property (p_stop) else $error("tx pin dominant in stop");
    property p_abort; pe_abort |-> bus_tx_pin; endproperty
    a_abort: assert property (p_abort) else $error("tx pin dominant in init");
    // dominant only ever comes from the transmitter stream, one stage late
    property p_dom; !bus_tx_pin |-> !$past(pe_tx_bit) && !$past(cpu_stop); endproperty
    a_dom: assert property (p_dom) else $error("dominant without cause");
    property p_loop; pe_loopback && $past(pe_loopback) |-> bus_tx_pin; endproperty
    a_loop: assert property (p_loop) else $error("tx pin dominant in loopback");
    property p_ack; pe_ack_enable |-> !pe_counter_freeze; endproperty
    a_ack: assert property (p_ack) else $error("ack enabled in listen only");
    property p_frz; pe_tx_enable |-> !pe_counter_freeze; endproperty
    a_frz: assert property (p_frz) else $error("transmit enabled in listen only");
    property p_sync; pe_abort |-> !pe_synced; endproperty
    a_sync: assert property (p_sync) else $error("synced while aborting");
    property p_rise; $rose(pe_synced) |-> !$past(pe_abort); endproperty
    a_rise: assert property (p_rise) else $error("sync without resync run");
    property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside answer");
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_asserts u_chk (.*);
`default_nettype wire

//--- cmc_bus_model.sv
// bus transceiver model: wired-and bus, recessive pull-up
`timescale 1ns/10ps
`default_nettype none
module cmc_bus_model (
    input wire logic tx_pin,
    input wire logic remote_dom,
    output logic rx_pin
);
    // any node pulling dominant wins; an idle bus floats recessive
    assign rx_pin = tx_pin & ~remote_dom;
endmodule
`default_nettype wire

//--- can_mode_control_handshake_tb.sv
// testbench: mode handshakes and transmit pin safety
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module can_mode_control_handshake_tb;
    import cmc_pkg::*;
    logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, special_mode = 0;
    logic cpu_stop = 0, cpu_wait = 0, pe_tx_bit = 1, pe_rx_busy = 0, pe_bit_tick = 0;
    logic pe_tx_pending = 0, pe_bus_off = 0, pe_rx_frame_event = 0, remote_dom = 0;
    logic [1:0] tx_state_field_in = 2'h0, rx_state_field_in = 2'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_val, reg_rdata;
    logic [7:0] bit_timing_reg_0, bit_timing_reg_1, acceptance_control_reg;
    logic bus_tx_pin, bus_rx_pin, pe_rx_bit, pe_abort, pe_synced, pe_loopback;
    logic pe_ack_enable, pe_err_frame_enable, pe_counter_freeze, pe_tx_enable;
    logic module_enable_bit, clock_source_select, timer_enable;
    int fail_count = 0, n_compared = 0, tick_div = 0;
    always #2 sys_clk = ~sys_clk;
    // short wake filter keeps the run brief; the shorter bus-off count plays no part, as pe_bus_off stays low
    cmc_mode_ctrl #(.TWUP_CYCLES(4), .BUSOFF_SEQS(2)) dut (.*);
    cmc_bus_model bus (.tx_pin(bus_tx_pin), .remote_dom(remote_dom), .rx_pin(bus_rx_pin));
    // sample point every fourth cycle
    always @(posedge sys_clk) begin
        tick_div <= tick_div + 1;
        pe_bit_tick <= (tick_div % 4 == 3);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // more keeps the strobe up for a write that follows at once, so it is driven once
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit more = 1'b0);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        if (!more) begin
            reg_wr <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        rd_val = reg_rdata;
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic t_init_cfg();
        rd(CMC_OFF_CTL1);
        `CHK("ctl1 rst", 8'h11, rd_val)
        `CHK("no err frames", 1'b0, pe_err_frame_enable)
        wr(CMC_OFF_CTL1, 8'hc7, 1'b1);
        wr(CMC_OFF_CTL1, 8'h40, 1'b1);
        wr(CMC_OFF_BTR0, 8'h5a, 1'b1);
        wr(8'h3f, 8'hff);
        rd(CMC_OFF_CTL1);
        `CHK("ctl1 once", 8'hc1, rd_val)
        `CHK("clock_source_select", 1'b1, clock_source_select)
        `CHK("btr0", 8'h5a, bit_timing_reg_0)
        special_mode <= 1'b1;
        wr(CMC_OFF_CTL1, 8'h24);
        rd(CMC_OFF_CTL1);
        `CHK("ctl1 spec", 8'h25, rd_val)
        `CHK("clock_source_select", 1'b0, clock_source_select)
        wr(CMC_OFF_CTL1, 8'hc6);
        special_mode <= 1'b0;
        rd(CMC_OFF_CTL1);
        `CHK("ctl1 ack", 8'hc5, rd_val)
        $display("test init config done");
    endtask
    task automatic t_run();
        int ticks;
        int i;
        ticks = 0;
        wr(CMC_OFF_CTL0, 8'h00);
        for (i = 0; i < 400 && pe_synced !== 1'b1; i++) begin
            @(posedge sys_clk);
            ticks += pe_bit_tick;
        end
        if (i == 400) begin
            fail_count++;
            end_of_test();
        end
        `CHK("idle bits", 1'b1, ticks >= CMC_IDLE_BITS)
        wr(CMC_OFF_CTL1, 8'h00, 1'b1);
        wr(CMC_OFF_BTR0, 8'h00);
        rd(CMC_OFF_CTL1);
        `CHK("ctl1 lock", 8'hc4, rd_val)
        `CHK("btr0 lock", 8'h5a, bit_timing_reg_0)
        `CHK("err frames", 1'b1, pe_err_frame_enable)
        pe_tx_bit <= 1'b0;
        cpu_wait <= 1'b1;
        cyc(3);
        `CHK("tx wait", 1'b0, bus_tx_pin)
        wr(CMC_OFF_CTL0, 8'h20);
        cyc(2);
        `CHK("tx wait stop", 1'b1, bus_tx_pin)
        cpu_wait <= 1'b0;
        cyc(3);
        `CHK("tx run", 1'b0, bus_tx_pin)
        cpu_stop <= 1'b1;
        cyc(2);
        `CHK("tx stop", 1'b1, bus_tx_pin)
        cpu_stop <= 1'b0;
        $display("test run done");
    endtask
    task automatic t_sleep_init();
        // engine recessive but receiving, so sleep waits and the wake detector sees no own dominant bit
        pe_tx_bit <= 1'b1;
        pe_rx_busy <= 1'b1;
        wr(CMC_OFF_CTL0, 8'h08, 1'b1);
        wr(CMC_OFF_CTL0, 8'h0e, 1'b1);
        wr(CMC_OFF_CTL0, 8'h0c);
        cyc(3);
        rd(CMC_OFF_CTL0);
        `CHK("ctl0 sleep", 8'h0e, rd_val)
        rd(CMC_OFF_CTL1);
        `CHK("no ack busy", 8'hc4, rd_val)
        pe_rx_busy <= 1'b0;
        cyc(3);
        rd(CMC_OFF_CTL1);
        `CHK("sleep ack", 8'hc6, rd_val)
        // a remote node holds the bus dominant longer than the filter
        remote_dom <= 1'b1;
        cyc(8);
        remote_dom <= 1'b0;
        rd(CMC_OFF_CTL1);
        `CHK("woke", 8'hc4, rd_val)
        rd(CMC_OFF_RFLG);
        `CHK("wake flag", 8'h80, rd_val)
        wr(CMC_OFF_RFLG, 8'h80, 1'b1);
        wr(CMC_OFF_CTL0, 8'h0e);
        cyc(3);
        // init is requested from sleep, the safe order for software
        wr(CMC_OFF_CTL0, 8'h0b, 1'b1);
        wr(CMC_OFF_CTL0, 8'h0a);
        cyc(2);
        rd(CMC_OFF_CTL0);
        `CHK("ctl0 init", 8'h03, rd_val)
        `CHK("timer", 1'b0, timer_enable)
        $display("test sleep init done");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_init_cfg();
        t_run();
        t_sleep_init();
        end_of_test();
    end
endmodule
`default_nettype wire
